// ===== hlt_timer.sv
module hlt_timer
    import hlt_pkg::*;
#(
    parameter int unsigned WIDTH = CNT_W
)
(
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    input  wire logic             run_set_i,
    input  wire logic             run_clr_i,
    input  wire logic [MODE_W-1:0] mode_i,
    input  wire logic [POST_W-1:0] postscale_sel_i,
    input  wire logic             period_wr_i,
    input  wire logic [WIDTH-1:0] period_wdata_i,
    input  wire logic             count_wr_i,
    input  wire logic [WIDTH-1:0] count_wdata_i,
    input  wire logic             ext_reset_signal_i,
    input  wire logic             timer_irq_enable_i,
    output logic                  run_o,
    output logic [WIDTH-1:0]      timer_count_o,
    output logic [WIDTH-1:0]      period_value_o,
    output logic                  period_match_o,
    output logic                  period_start_o,
    output logic                  postscaled_o,
    output logic                  irq_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The reset constants are eight bits wide, so wider counts cannot
    // take their reset values from them.
    if (WIDTH < 2 || WIDTH > CNT_W)
    begin : g_bad_width
        $error("hlt_timer WIDTH must be 2 to 8.");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                 run_q;
    logic [WIDTH-1:0]     cnt_q;
    logic [WIDTH-1:0]     cnt_d;
    logic [WIDTH-1:0]     per_q;
    logic [POST_W-1:0]    post_q;
    logic                 posted_q;
    logic                 irq_q;
    logic                 ers_prev_q;
    logic [1:0]           hold_q;
    logic                 start_q;
    logic [MODE_W-1:0]    mode_q;
    hlt_state_e           state_q;
    hlt_state_e           state_d;
    logic                 run_s;
    logic                 ers_s;

    // Software run bit; the hardware clear in one-shot modes wins over set.
    logic run_hw_clr;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            run_q <= 1'b0;
        else if (clk_en_i)
            run_q <= run_hw_clr ? 1'b0 : (run_set_i ? 1'b1 :
                     (run_clr_i ? 1'b0 : run_q));
    end

    // ------------------------------------------------------------------
    // Synchronisers for the run bit and the external signal
    // ------------------------------------------------------------------
    hlt_sync #(.STAGES(SYNC_STAGES)) u_sync_run
    (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clk_en_i   (clk_en_i),
        .async_i    (run_q),
        .sync_o     (run_s)
    );

    hlt_sync #(.STAGES(SYNC_STAGES)) u_sync_ers
    (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clk_en_i   (clk_en_i),
        .async_i    (ext_reset_signal_i),
        .sync_o     (ers_s)
    );

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire [1:0] grp = mode_i[4:3];
    wire [2:0] lo  = mode_i[2:0];
    wire rise      = ers_s & ~ers_prev_q;
    wire fall      = ~ers_s & ers_prev_q;

    // Edge selection shared by start and reset decoding.
    function automatic logic edge_hit(input logic [2:0] c,
                                      input logic r, input logic f);
        logic h;
        h = 1'b0;
        if (c == LO_ANY_EDGE)
            h = r | f;
        else if (c == LO_RISE || c == LO_GATE_HI || c == LO_LVL_LOW)
            h = r;
        else
            h = f;
        return h;
    endfunction : edge_hit

    wire is_free   = (grp == GRP_FREE);
    wire is_os     = (grp == GRP_ONESHOT);
    wire is_mono   = (grp == GRP_MONO) && (lo >= LO_GATE_HI)
                     && (lo <= LO_ANY_EDGE);
    wire is_lvl_os = (grp == GRP_MONO) && (lo >= LO_LVL_LOW);
    wire single    = is_os | is_mono | is_lvl_os;
    // Edge-started modes need an edge after the run bit goes high.
    wire edge_start = (is_os && lo != LO_SWGATE) || is_mono;
    // Start edge: codes 4/6 rise, 5/7 fall, 1/2/3 as their edge codes.
    wire [2:0] start_code = (lo == LO_RISE || lo == LO_LVL_LOW) ?
                            LO_GATE_HI :
                            ((lo == LO_FALL || lo == LO_LVL_HIGH) ?
                            LO_GATE_LO : lo);
    wire start_edge = edge_hit(start_code, rise, fall);

    // Active level of the reset for the level modes.
    wire lvl_active = (lo == LO_LVL_LOW) ? ~ers_s : ers_s;

    // Gate and reset terms for the free-running and one-shot modes.
    wire gate_stop = is_free && ((lo == LO_GATE_HI && ers_s) ||
                     (lo == LO_GATE_LO && !ers_s));
    wire free_edge_rst = is_free && (lo >= LO_ANY_EDGE) &&
                         (lo <= LO_FALL) && edge_hit(lo, rise, fall);
    wire free_lvl = is_free && (lo >= LO_LVL_LOW) && run_s;
    wire os_edge_rst = is_os && (lo == LO_RISE || lo == LO_FALL) &&
                       state_q == HLT_RUN && edge_hit(lo, rise, fall);
    wire os_lvl = is_os && (lo >= LO_LVL_LOW);
    wire edge_rst = free_edge_rst | os_edge_rst;
    // Level reset held: level limit, edge-start level reset, level start.
    wire lvl_hold = (free_lvl && lvl_active) ||
                    (os_lvl && lvl_active) ||
                    (is_lvl_os && ((lo == LO_LVL_LOW) ?
                     !ers_s : ers_s));

    // ------------------------------------------------------------------
    // Run state: idle until started, armed waiting for an edge, running
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            // The live run bit is needed too, so the stale synchronised
            // copy cannot restart the count after a hardware clear.
            HLT_IDLE:
                if (run_s && run_q)
                    state_d = edge_start ? HLT_ARM : HLT_RUN;
            HLT_ARM:
                if (!run_s)
                    state_d = HLT_IDLE;
                else if (start_edge || !edge_start)
                    state_d = HLT_RUN;
            HLT_RUN:
                if (!run_s)
                    state_d = HLT_IDLE;
                else if (run_hw_clr)
                    state_d = HLT_IDLE;
                else if (is_mono && period_match_o)
                    state_d = HLT_ARM;
                else if (os_lvl && lvl_hold)
                    state_d = HLT_ARM;
            default:
                state_d = HLT_IDLE;
        endcase
    end

    // Period match, only while counting.
    assign period_match_o = (cnt_q == per_q) && state_q == HLT_RUN &&
                            hold_q == 2'h0 && !gate_stop;
    assign run_hw_clr = (is_os || is_lvl_os) && period_match_o;

    // ------------------------------------------------------------------
    // Counter next value
    // ------------------------------------------------------------------
    wire restart = edge_rst || lvl_hold;
    always_comb
    begin
        cnt_d = cnt_q;
        if (count_wr_i)
            cnt_d = count_wdata_i;
        else if (restart)
            cnt_d = COUNT_ZERO[WIDTH-1:0];
        else if (state_q != HLT_RUN)
            cnt_d = cnt_q;
        else if (hold_q != 2'h0 || gate_stop)
            cnt_d = cnt_q;
        else if (period_match_o)
            cnt_d = COUNT_ZERO[WIDTH-1:0];
        else
            cnt_d = cnt_q + 1'b1;
    end

    // Counter, period and the two-clock restart delay.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cnt_q      <= '0;
            per_q      <= PERIOD_RST[WIDTH-1:0];
            state_q    <= HLT_IDLE;
            ers_prev_q <= 1'b0;
            hold_q     <= 2'h0;
            start_q    <= 1'b0;
            mode_q     <= '0;
        end
        else if (clk_en_i)
        begin
            cnt_q      <= cnt_d;
            state_q    <= state_d;
            ers_prev_q <= ers_s;
            mode_q     <= mode_i;
            if (period_wr_i)
                per_q <= period_wdata_i;
            // Reset holds the count; release waits two more clocks.
            if (restart)
                hold_q <= 2'(RESTART_CLKS);
            else if (hold_q != 2'h0)
                hold_q <= hold_q - 2'h1;
            start_q <= (hold_q == 2'h1) && !restart;
        end
    end

    assign period_start_o = start_q;

    // ------------------------------------------------------------------
    // Postscaler; cleared on count or mode writes and on resets
    // ------------------------------------------------------------------
    wire post_clr = count_wr_i || (mode_i != mode_q) || restart;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            post_q   <= '0;
            posted_q <= 1'b0;
            irq_q    <= 1'b0;
        end
        else if (clk_en_i)
        begin
            posted_q <= 1'b0;
            if (post_clr)
                post_q <= '0;
            else if (period_match_o)
            begin
                if (post_q == postscale_sel_i)
                begin
                    post_q   <= '0;
                    posted_q <= 1'b1;
                end
                else
                    post_q <= post_q + 1'b1;
            end
            // Set wins: a new event keeps the request up.
            irq_q <= (posted_q | irq_q) & timer_irq_enable_i &
                     !(irq_q && !posted_q);
        end
    end

    assign run_o          = run_q;
    assign timer_count_o  = cnt_q;
    assign period_value_o = per_q;
    assign postscaled_o   = posted_q;
    assign irq_o          = irq_q;

endmodule : hlt_timer

// ===== hlt_pkg.sv
package hlt_pkg;

    // ------------------------------------------------------------------
    // Widths and mode field layout
    // ------------------------------------------------------------------
    localparam int unsigned   CNT_W       = 8;
    localparam int unsigned   MODE_W      = 5;
    localparam int unsigned   POST_W      = 4;
    localparam int unsigned   SYNC_STAGES = 2;
    localparam logic [7:0]    PERIOD_RST  = 8'hFF;
    localparam logic [7:0]    COUNT_ZERO  = 8'h00;

    // ------------------------------------------------------------------
    // Mode groups in bits 4:3 and the low code in bits 2:0
    // ------------------------------------------------------------------
    localparam logic [1:0]    GRP_FREE    = 2'h0;
    localparam logic [1:0]    GRP_ONESHOT = 2'h1;
    localparam logic [1:0]    GRP_MONO    = 2'h2;
    localparam logic [2:0]    LO_SWGATE   = 3'h0;
    localparam logic [2:0]    LO_GATE_HI  = 3'h1;
    localparam logic [2:0]    LO_GATE_LO  = 3'h2;
    localparam logic [2:0]    LO_ANY_EDGE = 3'h3;
    localparam logic [2:0]    LO_RISE     = 3'h4;
    localparam logic [2:0]    LO_FALL     = 3'h5;
    localparam logic [2:0]    LO_LVL_LOW  = 3'h6;
    localparam logic [2:0]    LO_LVL_HIGH = 3'h7;

    // Delay from an external reset to the restart of counting.
    localparam int unsigned   RESTART_CLKS = 2;

    // Run state of the counter.
    typedef enum logic [2:0]
    {
        HLT_IDLE = 3'b001,
        HLT_ARM  = 3'b010,
        HLT_RUN  = 3'b100
    } hlt_state_e;

endpackage : hlt_pkg

// ===== hlt_sync.sv
module hlt_sync
    import hlt_pkg::*;
#(
    parameter int unsigned STAGES = SYNC_STAGES
)
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic clk_en_i,
    input  wire logic async_i,
    output logic      sync_o
);

    logic [STAGES-1:0] stage_q;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (STAGES < 2)
    begin : g_bad
        $error("hlt_sync needs at least two stages.");
    end

    // Only the last stage is visible, so the first flop feeds nothing else.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            stage_q <= '0;
        else if (clk_en_i)
            stage_q <= {stage_q[STAGES-2:0], async_i};
    end

    assign sync_o = stage_q[STAGES-1];

endmodule : hlt_sync

// ===== hlt_timer_asserts.sv
// ----------------------------------------------------------------------
// Port checker for the hardware limit timer
// ----------------------------------------------------------------------
module hlt_timer_asserts
    import hlt_pkg::*;
#(
    parameter int unsigned WIDTH = CNT_W
)
(
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic              clk_en_i,
    input wire logic              run_clr_i,
    input wire logic [MODE_W-1:0] mode_i,
    input wire logic              count_wr_i,
    input wire logic              ext_reset_signal_i,
    input wire logic              timer_irq_enable_i,
    input wire logic              run_o,
    input wire logic [WIDTH-1:0]  timer_count_o,
    input wire logic              period_match_o,
    input wire logic              period_start_o,
    input wire logic              postscaled_o,
    input wire logic              irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Match handling; the clear must land on the very next clock.
    AST_WRAP: assert property (
        period_match_o && clk_en_i && !count_wr_i |=> timer_count_o == '0)
        else $error("count not cleared after period match");
    AST_OS_CLR: assert property (
        mode_i[4:3] == GRP_ONESHOT && period_match_o && clk_en_i |=> !run_o)
        else $error("one-shot match left the run bit set");
    AST_MONO_KEEP: assert property (
        mode_i[4:3] == GRP_MONO && !mode_i[2] && period_match_o && clk_en_i
        && run_o && !run_clr_i && !count_wr_i
        |=> run_o && timer_count_o == '0)
        else $error("monostable match did not stop at zero with run set");
    // Run bit reaches the state three clocks late, so the windows are four.
    AST_SW_HOLD: assert property (
        (mode_i == 5'h00 && !run_o && clk_en_i)[*4] ##0 !count_wr_i
        |=> $stable(timer_count_o))
        else $error("count moved while stopped");
    AST_SW_INC: assert property (
        (mode_i == 5'h00 && run_o && clk_en_i)[*4]
        ##0 (!period_match_o && !count_wr_i)
        |=> timer_count_o == $past(timer_count_o) + 1'b1)
        else $error("count did not step by one");
    AST_GATE: assert property (
        (mode_i == 5'h01 && ext_reset_signal_i && clk_en_i && !count_wr_i)[*4]
        |=> $stable(timer_count_o))
        else $error("gate high did not suspend counting");
    AST_LVL_HOLD: assert property (
        (mode_i == 5'h07 && run_o && ext_reset_signal_i && clk_en_i
         && !count_wr_i)[*5] |-> timer_count_o == '0)
        else $error("level reset not holding count at zero");
    AST_IRQ_GATE: assert property (
        (!timer_irq_enable_i)[*2] |-> !irq_o)
        else $error("interrupt passed while disabled");
    AST_POST_PULSE: assert property (
        postscaled_o && clk_en_i |=> !postscaled_o)
        else $error("postscaled output wider than one clock");

    // Main scenarios reached.
    COV_START: cover property (period_start_o);
    COV_IRQ: cover property (irq_o);
    COV_MONO: cover property (mode_i[4:3] == GRP_MONO && period_match_o);
endmodule : hlt_timer_asserts

bind hlt_timer hlt_timer_asserts #(.WIDTH(WIDTH)) u_hlt_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .run_clr_i(run_clr_i), .mode_i(mode_i), .count_wr_i(count_wr_i),
    .ext_reset_signal_i(ext_reset_signal_i),
    .timer_irq_enable_i(timer_irq_enable_i), .run_o(run_o),
    .timer_count_o(timer_count_o), .period_match_o(period_match_o),
    .period_start_o(period_start_o), .postscaled_o(postscaled_o),
    .irq_o(irq_o)
);

// ===== hlt_ers_model.sv
// ----------------------------------------------------------------------
// Logic that drives the external reset signal
// ----------------------------------------------------------------------
module hlt_ers_model
(
    input  wire logic core_clk_i,
    output logic      ext_reset_signal_o
);
    timeunit 1ns;
    timeprecision 100ps;
    time last_t = 0;

    initial ext_reset_signal_o = 1'b0;

    // Any change waits six clocks from the last one, which also keeps
    // every level for at least three clocks.
    task automatic set(input logic v);
        @(posedge core_clk_i);
        while ($time - last_t < 30) @(posedge core_clk_i);
        ext_reset_signal_o <= v;
        last_t = $time;
    endtask : set
endmodule : hlt_ers_model

// ===== hlt_timer_tb_top.sv
// ----------------------------------------------------------------------
// Testbench for the hardware limit timer
// ----------------------------------------------------------------------
module hlt_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hlt_pkg::*;

    logic       clk = 0, rst = 1, clk_en = 1, run_set = 0, run_clr = 0;
    logic       pwr = 0, cwr = 0, irq_en = 0, ext;
    logic [4:0] mode = '0;
    logic [3:0] psel = '0;
    logic [7:0] pwd = '0, cwd = '0, cnt, per, c;
    logic       run, match, pstart, posts, irq;
    int         mismatches = 0, compares = 0, k, n, q;
    // Rows: mode, level before run, starting level, run bit after match.
    logic [7:0] rows [20] = '{8'h01, 8'h09, 8'h17, 8'h19, 8'h21, 8'h29,
        8'h37, 8'h39, 8'h40, 8'h4A, 8'h54, 8'h5A, 8'h62, 8'h6C, 8'h72,
        8'h7C, 8'h8B, 8'h95, 8'h9B, 8'hB2};

    hlt_ers_model p (.core_clk_i(clk), .ext_reset_signal_o(ext));
    hlt_timer dut (.core_clk_i(clk), .rst_i(rst), .clk_en_i(clk_en),
        .run_set_i(run_set), .run_clr_i(run_clr), .mode_i(mode),
        .postscale_sel_i(psel), .period_wr_i(pwr), .period_wdata_i(pwd),
        .count_wr_i(cwr), .count_wdata_i(cwd), .ext_reset_signal_i(ext),
        .timer_irq_enable_i(irq_en), .run_o(run), .timer_count_o(cnt),
        .period_value_o(per), .period_match_o(match),
        .period_start_o(pstart), .postscaled_o(posts), .irq_o(irq));

    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string s, input logic [7:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic tick(input int t);
        repeat (t) @(negedge clk);
    endtask : tick

    // One-clock control pulses; the strobe drops on the following edge.
    task automatic ctl(input logic s, input logic r, input logic w,
                       input logic v, input logic [7:0] d);
        @(posedge clk);
        run_set <= s;
        run_clr <= r;
        pwr <= w;
        cwr <= v;
        pwd <= d;
        cwd <= d;
        @(posedge clk);
        {run_set, run_clr, pwr, cwr} <= 4'h0;
    endtask : ctl

    // Stop first and let the run bit drain, so no stale match hits the
    // new mode; then program the period and clear the count.
    task automatic setup(input logic [4:0] m, input logic [7:0] pv);
        ctl(0, 1, 0, 0, 8'h00);
        tick(4);
        @(posedge clk);
        mode <= m;
        ctl(0, 0, 1, 0, pv);
        ctl(0, 0, 0, 1, 8'h00);
        tick(2);
    endtask : setup

    task automatic do_reset(input int t);
        @(posedge clk);
        rst <= 1'b1;
        repeat (t) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("reset count", cnt, 8'h00);
        chk("reset period", per, 8'hFF);
        chk("reset run", run, 1'b0);
    endtask : do_reset

    // Cycles until the next postscaled pulse, with interrupts seen meanwhile.
    task automatic gap(output int g, output int i);
        g = 0;
        i = 0;
        do
        begin
            @(negedge clk);
            g++;
            i += (irq === 1'b1);
        end while (posts !== 1'b1 && g < 100);
    endtask : gap

    initial
    begin
        #200000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        do_reset(16);
        foreach (rows[i])
        begin
            setup(rows[i][7:3], 8'h20);
            p.set(rows[i][2]);
            tick(8);
            ctl(1, 0, 0, 0, 8'h00);
            tick(6);
            if (rows[i][2] != rows[i][1])
                chk("wait for start edge", cnt, 8'h00);
            p.set(rows[i][1]);
            tick(1);
            for (k = 0; k < 300 && match !== 1'b1; k++) @(negedge clk);
            chk("match", match, 1'b1);
            tick(2);
            chk("run after match", run, rows[i][0]);
            chk("count after match", cnt,
                {7'h00, rows[i][7:6] == GRP_FREE});
        end
        // Count write holds while stopped, and a low enable freezes all.
        setup(5'h00, 8'h80);
        ctl(0, 0, 0, 1, 8'h3C);
        tick(6);
        chk("held count", cnt, 8'h3C);
        ctl(1, 0, 0, 0, 8'h00);
        tick(10);
        @(posedge clk);
        clk_en <= 1'b0;
        tick(1);
        c = cnt;
        tick(5);
        chk("frozen count", cnt, c);
        @(posedge clk);
        clk_en <= 1'b1;
        // Postscale ratios at both ends and in between, then the enable.
        setup(5'h00, 8'h02);
        ctl(1, 0, 0, 0, 8'h00);
        for (int j = 0; j < 3; j++)
        begin
            @(posedge clk);
            psel <= j == 0 ? 4'h0 : (j == 1 ? 4'hF : 4'h3);
            gap(n, q);
            gap(n, q);
            gap(n, q);
            chk("post gap", 8'(n), (psel + 8'h01) * 8'h03);
        end
        chk("irq masked", 8'(q), 8'h00);
        @(posedge clk);
        irq_en <= 1'b1;
        gap(n, q);
        gap(n, q);
        chk("irq passed", 8'(q), 8'h01);
        // Early rising edge resets the count and restarts two clocks on.
        setup(5'h04, 8'h40);
        p.set(1'b0);
        ctl(1, 0, 0, 0, 8'h00);
        tick(20);
        p.set(1'b1);
        for (k = 0; k < 12 && pstart !== 1'b1; k++) @(negedge clk);
        chk("period start", pstart, 1'b1);
        chk("early reset", cnt < 8'h04, 1'b1);
        // Level reset holds the count, release restarts it.
        setup(5'h07, 8'h40);
        p.set(1'b0);
        ctl(1, 0, 0, 0, 8'h00);
        tick(20);
        p.set(1'b1);
        tick(12);
        chk("level hold", cnt, 8'h00);
        p.set(1'b0);
        tick(8);
        chk("level restart", cnt != 8'h00, 1'b1);
        do_reset(2);
        end_of_test();
    end
endmodule : hlt_timer_tb_top
